// ### rtl/sct_pkg.sv
// Constants and types for the subsystem clock tree controller
// Overview of operation
// - CPU clock is PLL divided 1/2/4/8
// - CPU clock at most 625 MHz, not below AXI
// - AXI is CPU divided 1/2/4/8, max 312.5 MHz
// - AXI clock not below peripheral bus clock
// - Peripheral bus is CPU /2/4/8, max 156.25 MHz
// - Every PLL gives four outputs from one reference
// - Subsystem PLL outputs: CPU, crypto, eMMC, CAN
// - Enabled eMMC clock fixed at 200 MHz
// - CAN clock multiple of 8, at most 80 MHz
// - Crypto clock from 1 to 200 MHz
// - Memory PLL outputs all at memory clock
// - Serial PLL outputs 625 MHz, 90 degree steps
// - eMMC and CAN clock: PLL or fabric I/O
// - Subsystem reference: bank input or corner PLL
// - Bank reference only 100 or 125 MHz
// - Memory and serial references selectable likewise
// - Fabric port max 250 MHz, DLL from 125 MHz
// - All fabric port DLLs enabled by default
// - Fabric ports synchronise across clock domains
// - Ports 0-2 AXI4, port 3 APB, fixed roles
package sct_pkg;
  // Frequencies are carried in kHz
  localparam int KW = 20;
  typedef logic [KW-1:0] sct_khz_t;

  // Frequency limits in kHz
  localparam sct_khz_t CPU_MAX     = 20'h98968; // 625 MHz
  localparam sct_khz_t AXI_MAX     = 20'h4c4b4; // 312.5 MHz
  localparam sct_khz_t APB_MAX     = 20'h2625a; // 156.25 MHz
  localparam sct_khz_t EMMC_KHZ    = 20'h30d40; // 200 MHz
  localparam sct_khz_t CRYPTO_MAX  = 20'h30d40; // 200 MHz
  localparam sct_khz_t CRYPTO_MIN  = 20'h003e8; // 1 MHz
  localparam sct_khz_t CAN_STEP    = 20'h01f40; // 8 MHz
  localparam int       CAN_NUM     = 10;        // 8..80 MHz
  localparam sct_khz_t REF_A       = 20'h186a0; // 100 MHz
  localparam sct_khz_t REF_B       = 20'h1e848; // 125 MHz
  localparam sct_khz_t FIC_MAX     = 20'h3d090; // 250 MHz
  localparam sct_khz_t FIC_DLL_MIN = 20'h1e848; // 125 MHz
  localparam sct_khz_t LINK_KHZ    = 20'h98968; // 625 MHz

  // Divider codes are shift counts
  localparam logic [1:0] DIV_1 = 2'h0;
  // Clock source and reference selects
  localparam logic SRC_PLL    = 1'h0;
  localparam logic REF_BANK5  = 1'h0;
  // Port roles: bit n is fabric port n
  localparam logic [3:0] INI_CAP   = 4'hb;
  localparam logic [3:0] TGT_CAP   = 4'h7;
  localparam logic [3:0] APB_PORTS = 4'h8;
  localparam logic [3:0] DLL_RST   = 4'hf;

  // Domain reset hold time
  localparam int HOLD_NS = 1000;
  localparam int CLK_NS  = 100;
  localparam logic [3:0] HOLD_CYC =
    4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_TOP = HOLD_CYC - 4'h1;

  // Requested configuration
  typedef struct packed {
    sct_khz_t            pll;
    logic [1:0]          cpu_div;
    logic [1:0]          axi_div;
    logic [1:0]          apb_div;
    logic                mss_ref;
    logic                mem_ref;
    logic                link_ref;
    sct_khz_t            ref5;
    logic                emmc_en;
    logic                emmc_src;
    logic                can_en;
    logic                can_src;
    sct_khz_t            can;
    sct_khz_t            crypto;
    sct_khz_t            mem;
    logic [3:0]          ini_en;
    logic [3:0]          tgt_en;
    sct_khz_t [3:0]      fabric_interface_ctrl;
  } sct_cfg_t;

  // Applied clock plan
  typedef struct packed {
    sct_khz_t            cpu;
    sct_khz_t            axi;
    sct_khz_t            apb;
    sct_khz_t [3:0]      mss_out;
    sct_khz_t [3:0]      mem_out;
    sct_khz_t [3:0]      link_out;
    logic [3:0][1:0]     link_phase;
    logic                emmc_src;
    logic                can_src;
    logic                mss_ref;
    logic                mem_ref;
    logic                link_ref;
    logic [3:0]          dll_en;
    logic [3:0]          ini_en;
    logic [3:0]          tgt_en;
    logic [3:0]          apb_port;
  } sct_clk_t;

  // Rejection causes
  typedef struct packed {
    logic cpu;
    logic axi;
    logic apb;
    logic can;
    logic crypto;
    logic refc;
    logic fabric_interface_ctrl;
  } sct_err_t;
  localparam sct_err_t NO_ERR = 7'h00;

  // Apply sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_LOAD = 2'b10,
    ST_REL  = 2'b11
  } sct_fsm_t;
endpackage : sct_pkg

// ### rtl/sct_clock_tree.sv
// Clock tree configuration controller with fabric port crossing
module sct_clock_tree (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // Configuration request
  input  wire sct_pkg::sct_cfg_t i_cfg,
  input  wire logic              i_apply,
  // Fabric side levels
  input  wire logic [3:0]        i_fab_req,
  // Status and plan
  output sct_pkg::sct_clk_t      o_clk,
  output sct_pkg::sct_err_t      o_err,
  output logic                   o_cfg_ok,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_dom_rst_b,
  output logic [3:0]             o_fab_sync
);

  // Whole module state
  typedef struct packed {
    sct_pkg::sct_fsm_t st;   // Sequencer
    logic [3:0]        cnt;  // Hold counter
    sct_pkg::sct_cfg_t pend; // Accepted request
    sct_pkg::sct_clk_t clk;  // Applied plan
    sct_pkg::sct_err_t err;  // Last check
    logic              done; // Apply finished
    logic [3:0]        s1;   // Sync stage one
    logic [3:0]        s2;   // Sync stage two
  } sct_state_t;

  sct_state_t state_reg;  // Registered state
  sct_state_t state_next; // Next state

  // Plan after reset: DLLs on, serial PLL fixed
  function automatic sct_pkg::sct_clk_t rst_clk();
    sct_pkg::sct_clk_t k;
    k = '0;
    k.dll_en   = sct_pkg::DLL_RST;
    k.apb_port = sct_pkg::APB_PORTS;
    for (int i = 0; i < 4; i++) begin
      // Quarter turn per output
      k.link_out[i]   = sct_pkg::LINK_KHZ;
      k.link_phase[i] = 2'(i);
    end
    return k;
  endfunction : rst_clk

  // Check CAN clock against the allowed steps
  function automatic logic can_ok(sct_pkg::sct_khz_t x);
    logic r;
    r = 1'b0;
    for (int i = 1; i <= sct_pkg::CAN_NUM; i++) begin
      if (x == sct_pkg::sct_khz_t'(sct_pkg::CAN_STEP * i)) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : can_ok

  // Derive the full clock plan from a request
  function automatic sct_pkg::sct_clk_t derive(sct_pkg::sct_cfg_t c);
    sct_pkg::sct_clk_t k;
    k = rst_clk();
    // Bus clocks from the subsystem PLL
    k.cpu = c.pll >> c.cpu_div;
    k.axi = k.cpu >> c.axi_div;
    k.apb = k.cpu >> c.apb_div;
    // Subsystem PLL outputs, one per consumer
    k.mss_out[0] = c.pll;
    k.mss_out[1] = c.crypto;
    k.mss_out[2] = c.emmc_en ? sct_pkg::EMMC_KHZ : '0;
    k.mss_out[3] = c.can_en ? c.can : '0;
    // Memory PLL runs all outputs alike
    for (int i = 0; i < 4; i++) begin
      k.mem_out[i] = c.mem;
      // DLL only where insertion delay matters
      k.dll_en[i] = c.fabric_interface_ctrl[i] >= sct_pkg::FIC_DLL_MIN;
    end
    // Source and reference selects
    k.emmc_src = c.emmc_src;
    k.can_src  = c.can_src;
    k.mss_ref  = c.mss_ref;
    k.mem_ref  = c.mem_ref;
    k.link_ref = c.link_ref;
    // Roles limited to what each port can do
    k.ini_en = c.ini_en & sct_pkg::INI_CAP;
    k.tgt_en = c.tgt_en & sct_pkg::TGT_CAP;
    return k;
  endfunction : derive

  // Validate a request; any set bit refuses it
  function automatic sct_pkg::sct_err_t chk(sct_pkg::sct_cfg_t c);
    sct_pkg::sct_err_t e;
    sct_pkg::sct_clk_t k;
    logic              b5;
    logic [3:0]        on;
    e  = sct_pkg::NO_ERR;
    k  = derive(c);
    on = c.ini_en | c.tgt_en;
    // Any reference taken from the bank input
    b5 = (c.mss_ref == sct_pkg::REF_BANK5) ||
         (c.mem_ref == sct_pkg::REF_BANK5) ||
         (c.link_ref == sct_pkg::REF_BANK5);
    e.cpu = (k.cpu > sct_pkg::CPU_MAX) || (k.cpu < k.axi);
    e.axi = (k.axi > sct_pkg::AXI_MAX) || (k.axi < k.apb);
    // No divide-by-one on the peripheral bus
    e.apb = (c.apb_div == sct_pkg::DIV_1) ||
            (k.apb > sct_pkg::APB_MAX);
    // Fabric-fed CAN clock is not ours to check
    e.can = c.can_en && (c.can_src == sct_pkg::SRC_PLL) &&
            !can_ok(c.can);
    e.crypto = (c.crypto < sct_pkg::CRYPTO_MIN) ||
               (c.crypto > sct_pkg::CRYPTO_MAX);
    e.refc = b5 && (c.ref5 != sct_pkg::REF_A) &&
             (c.ref5 != sct_pkg::REF_B);
    // Unsupported role or overspeed port
    e.fabric_interface_ctrl = |(c.ini_en & ~sct_pkg::INI_CAP) ||
            |(c.tgt_en & ~sct_pkg::TGT_CAP);
    for (int i = 0; i < 4; i++) begin
      if (on[i] && (c.fabric_interface_ctrl[i] > sct_pkg::FIC_MAX)) begin
        e.fabric_interface_ctrl = 1'b1;
      end
    end
    return e;
  endfunction : chk

  // Next-state logic
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    // Two-flop crossing of fabric levels
    state_next.s1 = i_fab_req;
    state_next.s2 = state_reg.s1;
    case (state_reg.st)
      sct_pkg::ST_IDLE: begin
        // A refused request never touches the clocks
        if (i_apply) begin
          state_next.err = chk(i_cfg);
          if (chk(i_cfg) == sct_pkg::NO_ERR) begin
            state_next.pend = i_cfg;
            state_next.st   = sct_pkg::ST_HOLD;
            state_next.cnt  = sct_pkg::CNT_TOP;
          end
        end
      end
      sct_pkg::ST_HOLD: begin
        // Let domains settle in reset first
        if (state_reg.cnt == '0) begin
          state_next.st = sct_pkg::ST_LOAD;
        end else begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end
      end
      sct_pkg::ST_LOAD: begin
        // Switch only while reset is held, so no runt pulses
        state_next.clk = derive(state_reg.pend);
        state_next.st  = sct_pkg::ST_REL;
        state_next.cnt = sct_pkg::CNT_TOP;
      end
      sct_pkg::ST_REL: begin
        // Let new clocks run before release
        if (state_reg.cnt == '0) begin
          state_next.st   = sct_pkg::ST_IDLE;
          state_next.done = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end
      end
      default: begin
        state_next.st = sct_pkg::ST_IDLE;
      end
    endcase
    // Synchronous reset to defaults
    if (!i_rst_b) begin
      state_next     = '0;
      state_next.clk = rst_clk();
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
  end

  // Outputs
  assign o_clk       = state_reg.clk;
  assign o_err       = state_reg.err;
  assign o_cfg_ok    = state_reg.err == sct_pkg::NO_ERR;
  assign o_busy      = state_reg.st != sct_pkg::ST_IDLE;
  assign o_done      = state_reg.done;
  assign o_dom_rst_b = state_reg.st == sct_pkg::ST_IDLE;
  assign o_fab_sync  = state_reg.s2;

  // Checks on the applied plan, domain reset and fabric crossing
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_cpu_div_ratio: assert property (
    state_reg.st == sct_pkg::ST_LOAD |=>
      o_clk.cpu == ($past(state_reg.pend.pll) >>
                    $past(state_reg.pend.cpu_div)))
    else $error("cpu clock not pll over divider");
  a_cpu_limits: assert property (
    o_clk.cpu <= sct_pkg::CPU_MAX && o_clk.cpu >= o_clk.axi)
    else $error("cpu clock out of range");
  a_axi_limit: assert property (
    o_clk.axi <= sct_pkg::AXI_MAX)
    else $error("axi clock too fast");
  a_axi_over_apb: assert property (
    o_clk.axi >= o_clk.apb)
    else $error("axi clock below bus clock");
  a_apb_limits: assert property (
    o_clk.apb <= sct_pkg::APB_MAX && o_clk.apb <= (o_clk.cpu >> 1))
    else $error("bus clock out of range");
  a_emmc_fixed: assert property (
    o_clk.mss_out[2] == '0 || o_clk.mss_out[2] == sct_pkg::EMMC_KHZ)
    else $error("emmc clock not fixed");
  a_can_step: assert property (
    o_clk.can_src != sct_pkg::SRC_PLL || can_ok(o_clk.mss_out[3]) ||
    o_clk.mss_out[3] == '0)
    else $error("can clock not a legal step");
  a_mem_equal: assert property (
    o_clk.mem_out[0] == o_clk.mem_out[3] &&
    o_clk.mem_out[1] == o_clk.mem_out[2])
    else $error("memory pll outputs differ");
  a_link_phase: assert property (
    o_clk.link_out[3] == sct_pkg::LINK_KHZ && o_clk.link_phase[3] == 2'h3)
    else $error("serial pll output wrong");
  a_dll_thresh: assert property (
    state_reg.st == sct_pkg::ST_LOAD |=>
      o_clk.dll_en[0] == ($past(state_reg.pend.fabric_interface_ctrl[0]) >= sct_pkg::FIC_DLL_MIN))
    else $error("dll enable wrong for port speed");
  a_sync_delay: assert property (
    ##2 o_fab_sync == $past(i_fab_req, 2))
    else $error("fabric crossing not two stages");
  a_port_roles: assert property (
    (o_clk.ini_en & ~sct_pkg::INI_CAP) == '0 &&
    (o_clk.tgt_en & ~sct_pkg::TGT_CAP) == '0)
    else $error("port role not supported");
  a_hold_len: assert property (
    $fell(o_dom_rst_b) |-> !o_dom_rst_b [*8])
    else $error("domain reset too short");
  a_load_in_rst: assert property (
    $changed(o_clk) |-> !o_dom_rst_b && !$past(o_dom_rst_b))
    else $error("clocks changed outside reset");
  // Plan fields copied at load, checked one cycle on
  a_out_assign: assert property (
    state_reg.st == sct_pkg::ST_LOAD |=>
      o_clk.mss_out[0] == $past(state_reg.pend.pll) &&
      o_clk.mss_out[1] == $past(state_reg.pend.crypto))
    else $error("subsystem pll outputs misassigned");
  a_crypto_range: assert property (
    state_reg.st == sct_pkg::ST_LOAD |=>
      o_clk.mss_out[1] >= sct_pkg::CRYPTO_MIN && o_clk.mss_out[1] <= sct_pkg::CRYPTO_MAX)
    else $error("crypto clock out of range");
  a_src_copy: assert property (
    state_reg.st == sct_pkg::ST_LOAD |=>
      o_clk.emmc_src == $past(state_reg.pend.emmc_src) &&
      o_clk.can_src == $past(state_reg.pend.can_src))
    else $error("clock source select not applied");
  a_mss_ref_copy: assert property (
    state_reg.st == sct_pkg::ST_LOAD |=>
      o_clk.mss_ref == $past(state_reg.pend.mss_ref))
    else $error("subsystem reference select not applied");
  a_other_ref_copy: assert property (
    state_reg.st == sct_pkg::ST_LOAD |=>
      o_clk.mem_ref == $past(state_reg.pend.mem_ref) &&
      o_clk.link_ref == $past(state_reg.pend.link_ref))
    else $error("memory or serial reference select not applied");
  // Serial PLL plan is fixed in every state
  a_link_set: assert property (
    o_clk.link_out[0] == sct_pkg::LINK_KHZ && o_clk.link_out[1] == sct_pkg::LINK_KHZ &&
    o_clk.link_out[2] == sct_pkg::LINK_KHZ && o_clk.link_phase[1] == 2'h1 &&
    o_clk.link_phase[2] == 2'h2)
    else $error("serial pll output set incomplete");
  // Request checks seen from the ports
  a_bank_refuse: assert property (
    i_apply && !o_busy && i_cfg.mss_ref == sct_pkg::REF_BANK5 &&
    i_cfg.ref5 != sct_pkg::REF_A && i_cfg.ref5 != sct_pkg::REF_B |=>
      !o_cfg_ok && o_err.refc && !o_busy)
    else $error("bad bank reference accepted");
  a_refuse_keep: assert property (
    i_apply && !o_busy && chk(i_cfg) != sct_pkg::NO_ERR |=>
      !o_busy && o_dom_rst_b && $stable(o_clk))
    else $error("refused request touched the clocks");
  // Defaults right after reset and fixed port roles
  a_dll_default: assert property (
    !$past(i_rst_b) |-> o_clk.dll_en == sct_pkg::DLL_RST)
    else $error("dll not on after reset");
  a_apb_port: assert property (
    o_clk.apb_port == sct_pkg::APB_PORTS)
    else $error("apb port role moved");

  // Main scenarios
  c_accept: cover property (state_reg.st == sct_pkg::ST_LOAD);
  c_refuse: cover property (i_apply && !o_busy ##1 !o_cfg_ok);
  c_bypass: cover property (o_done && o_clk.dll_en != sct_pkg::DLL_RST);
  c_fab_can: cover property (o_done && o_clk.can_src != sct_pkg::SRC_PLL);
  c_bank_ref: cover property (o_done && o_clk.mss_ref == sct_pkg::REF_BANK5);

endmodule : sct_clock_tree

// ### dv/sct_fab_model.sv
// Fabric user logic model driving the crossing levels
module sct_fab_model (
  // Clock and run control
  input  wire logic       i_clk,
  input  wire logic       i_run,
  // Levels toward the fabric port
  output logic [3:0]      o_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Fabric logic has no synchronisers of its own; every port has a partner
  always @(posedge i_clk) begin
    if (i_run) begin
      o_req <= 4'($urandom);
    end else begin
      // Quiet until running, so reset sees stable levels
      o_req <= 4'h0;
    end
  end
endmodule : sct_fab_model

// ### dv/sct_clock_tree_tb.sv
// Self-checking bench for the clock tree controller
module sct_clock_tree_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Design inputs, all but i_fab_req known at time zero
  logic              i_clk   = 1'b0;
  logic              i_rst_b = 1'b0;
  sct_pkg::sct_cfg_t i_cfg   = '0;
  logic              i_apply = 1'b0;
  logic [3:0]        i_fab_req;
  // Design outputs
  sct_pkg::sct_clk_t o_clk;
  sct_pkg::sct_err_t o_err;
  logic              o_cfg_ok;
  logic              o_busy;
  logic              o_done;
  logic              o_dom_rst_b;
  logic [3:0]        o_fab_sync;
  // Scoreboard state
  int                fail_count = 0;
  int                compares   = 0;
  int                seen       = 0;
  logic              took       = 1'b0;
  logic              fab_run    = 1'b0;
  logic [3:0]        h1, h2;
  sct_pkg::sct_clk_t prev_clk;
  sct_pkg::sct_clk_t def;
  sct_pkg::sct_err_t q_err[$];
  sct_pkg::sct_clk_t q_clk[$];

  // 10 MHz clock
  always #50 i_clk = ~i_clk;

  sct_clock_tree uut (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_cfg       (i_cfg),
    .i_apply     (i_apply),
    .i_fab_req   (i_fab_req),
    .o_clk       (o_clk),
    .o_err       (o_err),
    .o_cfg_ok    (o_cfg_ok),
    .o_busy      (o_busy),
    .o_done      (o_done),
    .o_dom_rst_b (o_dom_rst_b),
    .o_fab_sync  (o_fab_sync)
  );

  sct_fab_model fab (
    .i_clk (i_clk),
    .i_run (fab_run),
    .o_req (i_fab_req)
  );

  // One compare task per kind of result
  task automatic cmp_clk(string n, sct_pkg::sct_clk_t e, sct_pkg::sct_clk_t g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : cmp_clk

  task automatic cmp_err(string n, sct_pkg::sct_err_t e, sct_pkg::sct_err_t g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : cmp_err

  task automatic cmp_bits(string n, logic [3:0] e, logic [3:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : cmp_bits

  // Plan the tree should settle on for a config
  function automatic sct_pkg::sct_clk_t plan(sct_pkg::sct_cfg_t c);
    sct_pkg::sct_clk_t p;
    p = '0;
    p.cpu = c.pll >> c.cpu_div;
    p.axi = p.cpu >> c.axi_div;
    p.apb = p.cpu >> c.apb_div;
    p.mss_out[0] = c.pll;
    p.mss_out[1] = c.crypto;
    p.mss_out[2] = c.emmc_en ? sct_pkg::EMMC_KHZ : '0;
    p.mss_out[3] = c.can_en ? c.can : '0;
    for (int i = 0; i < 4; i++) begin
      p.mem_out[i] = c.mem;
      p.link_out[i] = sct_pkg::LINK_KHZ;
      p.link_phase[i] = 2'(i);
      p.dll_en[i] = c.fabric_interface_ctrl[i] >= sct_pkg::FIC_DLL_MIN;
    end
    p.emmc_src = c.emmc_src;
    p.can_src = c.can_src;
    p.mss_ref = c.mss_ref;
    p.mem_ref = c.mem_ref;
    p.link_ref = c.link_ref;
    p.ini_en = c.ini_en & 4'hb;
    p.tgt_en = c.tgt_en & 4'h7;
    p.apb_port = 4'h8;
    return p;
  endfunction : plan

  // Causes for which a config must be refused
  function automatic sct_pkg::sct_err_t chk(sct_pkg::sct_cfg_t c);
    sct_pkg::sct_err_t e;
    sct_pkg::sct_clk_t p;
    p = plan(c);
    e = '0;
    e.cpu = p.cpu > sct_pkg::CPU_MAX || p.cpu < p.axi;
    e.axi = p.axi > sct_pkg::AXI_MAX || p.axi < p.apb;
    e.apb = c.apb_div == 2'h0 || p.apb > sct_pkg::APB_MAX;
    e.can = c.can_en && !c.can_src && (c.can % sct_pkg::CAN_STEP != 0
            || c.can == 0 || c.can > 20'h13880);
    e.crypto = c.crypto < sct_pkg::CRYPTO_MIN || c.crypto > sct_pkg::CRYPTO_MAX;
    e.refc = (!c.mss_ref || !c.mem_ref || !c.link_ref)
             && c.ref5 != sct_pkg::REF_A && c.ref5 != sct_pkg::REF_B;
    e.fabric_interface_ctrl = c.ini_en[2] || c.tgt_en[3];
    for (int i = 0; i < 4; i++) begin
      if ((c.ini_en[i] || c.tgt_en[i]) && c.fabric_interface_ctrl[i] > sct_pkg::FIC_MAX) e.fabric_interface_ctrl = 1'b1;
    end
    return e;
  endfunction : chk

  // Legal random config; divider code n, DLL threshold at its edge
  function automatic sct_pkg::sct_cfg_t rnd_cfg(int n);
    sct_pkg::sct_cfg_t c;
    c = '0;
    c.cpu_div = 2'(n);
    c.axi_div = 2'(1 + $urandom % 2);
    c.apb_div = c.axi_div + 2'h1;
    c.pll = 20'($urandom % 625001);
    {c.mss_ref, c.mem_ref, c.link_ref, c.emmc_en, c.emmc_src, c.can_en, c.can_src} = 7'($urandom);
    c.ref5 = ($urandom % 2) ? sct_pkg::REF_A : sct_pkg::REF_B;
    c.can = 20'(8000 * (1 + $urandom % 10));
    c.crypto = 20'(1000 + $urandom % 199001);
    c.mem = 20'($urandom % 800001);
    c.ini_en = 4'($urandom) & 4'hb;
    c.tgt_en = 4'($urandom) & 4'h7;
    for (int i = 0; i < 4; i++) c.fabric_interface_ctrl[i] = 20'($urandom % 250001);
    c.fabric_interface_ctrl[0] = sct_pkg::FIC_DLL_MIN - 20'(n % 2);
    return c;
  endfunction : rnd_cfg

  // Legal base with one fault per cause
  function automatic sct_pkg::sct_cfg_t bad_cfg(int k);
    sct_pkg::sct_cfg_t c;
    c = '0;
    c.pll = 20'h61a80;
    c.cpu_div = 2'h1;
    c.apb_div = 2'h1;
    c.crypto = sct_pkg::CRYPTO_MIN;
    c.ref5 = sct_pkg::REF_A;
    case (k)
      0: {c.pll, c.cpu_div, c.axi_div, c.apb_div} = {20'haae60, 2'h0, 2'h2, 2'h3};
      1: {c.cpu_div, c.apb_div} = {2'h0, 2'h2};
      2: c.apb_div = 2'h0;
      3: {c.can_en, c.can} = {1'b1, 20'h01f41};
      4: c.crypto = 20'h30d41;
      5: c.ref5 = 20'h1adb0;
      default: c.ini_en = 4'h4;
    endcase
    return c;
  endfunction : bad_cfg

  // Driver: notes the expected outcome, then requests
  task automatic apply(sct_pkg::sct_cfg_t c);
    sct_pkg::sct_err_t e;
    int n;
    e = chk(c);
    q_err.push_back(e);
    if (e === '0) q_clk.push_back(plan(c));
    i_cfg <= c;
    i_apply <= 1'b1;
    @(posedge i_clk);
    i_apply <= 1'b0;
    took <= 1'b1;
    @(posedge i_clk);
    took <= 1'b0;
    // A bad request while busy must be ignored
    if (e === '0) begin
      i_cfg <= '1;
      i_apply <= 1'b1;
    end
    @(posedge i_clk);
    i_apply <= 1'b0;
    n = 0;
    @(negedge i_clk);
    while (o_busy !== 1'b0) begin
      n++;
      if (n > 60) begin
        fail_count++;
        close_out();
      end
      @(negedge i_clk);
    end
    @(posedge i_clk);
  endtask : apply

  // Monitor: compares each result with the oldest note
  always @(posedge i_clk) begin
    if (took) begin
      cmp_err("o_err", q_err[0], o_err);
      cmp_bits("o_cfg_ok", {3'h0, q_err[0] === '0}, {3'h0, o_cfg_ok});
      cmp_bits("o_dom_rst_b", {3'h0, q_err[0] !== '0}, {3'h0, o_dom_rst_b});
      cmp_bits("o_busy", {3'h0, q_err[0] === '0}, {3'h0, o_busy});
      void'(q_err.pop_front());
    end
    if (o_done === 1'b1) begin
      cmp_clk("o_clk", q_clk.pop_front(), o_clk);
      cmp_err("o_err held", '0, o_err);
    end
    // The plan may only move while domains sit in reset
    if (seen > 3 && o_clk !== prev_clk) cmp_bits("reset at change", 4'h0, {3'h0, o_dom_rst_b});
    if (seen > 3) cmp_bits("o_fab_sync", h2, o_fab_sync);
    prev_clk <= o_clk;
    seen <= i_rst_b ? seen + 1 : 0;
    h2 <= h1;
    h1 <= i_fab_req;
  end

  // Verdict and end of run
  task automatic close_out();
    $display("TB: compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    void'($urandom(32'h951adcc4));
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    fab_run <= 1'b1;
    @(negedge i_clk);
    def = plan('0);
    def.dll_en = 4'hf;
    cmp_clk("reset plan", def, o_clk);
    cmp_bits("reset ok", 4'h1, {3'h0, o_cfg_ok});
    @(posedge i_clk);
    for (int n = 0; n < 4; n++) apply(rnd_cfg(n));
    for (int k = 0; k < 7; k++) apply(bad_cfg(k));
    for (int n = 0; n < 2; n++) apply(rnd_cfg(3 - n));
    @(negedge i_clk);
    cmp_bits("notes left", 4'h0, 4'(q_clk.size() + q_err.size()));
    close_out();
  end
endmodule : sct_clock_tree_tb
